// file: readout_cfg.svh
// Purpose: Constants for the serial result readout port
// Assumes: Included by bare name; definitions only
// Notes:   Times in ns or MHz, counts derived in the modules
`ifndef READOUT_CFG_SVH
`define READOUT_CFG_SVH
`define RESULT_BITS       16
`define SYNC_STAGES       2
`define CLK_PERIOD_NS     5
`define MAX_SCLK_MHZ      40
`define RESULT_RESET      16'h0000
`define BIT_CNT_RESET     5'h00
`endif

// file: readout_pkg.sv
// Purpose: Types shared by the readout port modules
// Assumes: readout_cfg.svh supplies the numbers
// Notes:   Gray-coded readout states
`include "readout_cfg.svh"
package readout_pkg;
  typedef logic [`RESULT_BITS-1:0] result_word_t;
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b11
  } readout_state_t;
endpackage

// file: pin_sync_if.sv
// Purpose: Bundle of synchronised host pins passed to the readout core
// Assumes: All signals on core_clk_i
// Notes:   Edge pulses are one core cycle wide
`timescale 1ns/1ps
interface pin_sync_if;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_n;
  logic rd_n;
  logic casc_in;
  logic busy;
  modport src (output sclk_rise, output sclk_fall, output sel_n, output rd_n,
               output casc_in, output busy);
  modport dst (input sclk_rise, input sclk_fall, input sel_n, input rd_n,
               input casc_in, input busy);
endinterface

// file: pin_sync.sv
// Purpose: Two-stage synchronisers and link clock edge detection
// Assumes: Host pins asynchronous to core_clk_i
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync
(
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  input  wire logic sclk_i,
  input  wire logic cs_n_i,
  input  wire logic rd_n_i,
  input  wire logic casc_i,
  input  wire logic busy_i,
  pin_sync_if.src   sync
);
  logic [4:0] meta_reg;
  logic [4:0] stab_reg;
  logic       sclk_prev_reg;

  // Two flip-flop synchronisers; cs/rd reset high so the port starts deselected
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      meta_reg      <= 5'h06;
      stab_reg      <= 5'h06;
      sclk_prev_reg <= 1'b0;
    end
    else
    begin
      meta_reg      <= {busy_i, casc_i, rd_n_i, cs_n_i, sclk_i};
      stab_reg      <= meta_reg;
      sclk_prev_reg <= stab_reg[0];
    end
  end

  // Edges seen only from the stable stage
  assign sync.sclk_rise = stab_reg[0] & ~sclk_prev_reg;
  assign sync.sclk_fall = ~stab_reg[0] & sclk_prev_reg;
  assign sync.sel_n     = stab_reg[1];
  assign sync.rd_n      = stab_reg[2];
  assign sync.casc_in   = stab_reg[3];
  assign sync.busy      = stab_reg[4];
endmodule

// file: serial_result_readout.sv
// Purpose: Slave serial readout of a 16-bit conversion result
// Assumes: Host shift clock sampled by core_clk_i at 200 MHz
// Notes:   Data shifts on link clock falling edge, cascade latched on rising edge
`timescale 1ns/1ps
`include "readout_cfg.svh"

// Contract
// - Serial port used when serial select high; external clock when source select high.
// - Host clock ignored while chip select is high.
// - Outputs released whenever chip select or read enable is high.
// - After-conversion read allowed once busy falls, with select and read low.
// - Sixteen bits, MSB first, each stable across both clock edges.
// - External clock up to 40 MHz accepted in after-conversion mode.
// - Daisy chain only in external-clock after-conversion mode via cascade input.
// - Cascade latched on opposite edge; upstream MSB follows our LSB.
// - During conversion the previous result is shifted out.
// - Incomplete read at conversion end gives a high read-error pulse; code pulses only for reads begun during that conversion.
// - No chaining during conversion reads; mode input held static.
// - Read begun after conversion may continue into the next conversion.
module serial_result_readout
  import readout_pkg::*;
#(
  parameter int RESULT_W = `RESULT_BITS
)
(
  input  wire logic                core_clk_i,
  input  wire logic                nrst_i,
  input  wire logic                serial_parallel_select_i,
  input  wire logic                clock_source_select_i,
  input  wire logic                cascade_in_read_mode_sel_i,
  input  wire logic                sclk_i,
  input  wire logic                cs_n_i,
  input  wire logic                rd_n_i,
  input  wire logic                busy_i,
  input  wire logic [RESULT_W-1:0] result_i,
  output logic                     serial_result_out_o,
  output logic                     serial_result_out_oe_n_o,
  output logic                     read_overrun_pulse_o,
  output logic                     read_active_o
);
  // Shortest link half period in core cycles at the 40 MHz limit
  localparam int SCLK_MIN_HALF_CYC =
    (1000 / (2 * `MAX_SCLK_MHZ)) / `CLK_PERIOD_NS;

  pin_sync_if sync ();

  logic [RESULT_W-1:0] shift_reg;
  logic [4:0]          bit_cnt_reg;
  logic                casc_bit_reg;
  logic                busy_prev_reg;
  logic                during_reg;
  readout_state_t      state_reg;
  logic                port_on;
  logic                enabled;

  pin_sync u_sync
  (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .sclk_i     (sclk_i),
    .cs_n_i     (cs_n_i),
    .rd_n_i     (rd_n_i),
    .casc_i     (cascade_in_read_mode_sel_i),
    .busy_i     (busy_i),
    .sync       (sync)
  );

  // Port active only in external-clock serial mode
  assign port_on = serial_parallel_select_i & clock_source_select_i;
  // Chip select gates the host clock; read enable ANDed in as well
  assign enabled = port_on & ~sync.sel_n & ~sync.rd_n;

  // Busy edge tracking for load and overrun detection
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
      busy_prev_reg <= 1'b0;
    else
      busy_prev_reg <= sync.busy;
  end

  // Readout state and shift register
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      state_reg    <= ST_IDLE;
      shift_reg    <= `RESULT_RESET;
      bit_cnt_reg  <= `BIT_CNT_RESET;
      casc_bit_reg <= 1'b0;
      during_reg   <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          // Load a fresh word when busy falls, or the previous one at busy rise
          if (busy_prev_reg && !sync.busy)
          begin
            shift_reg   <= result_i;
            bit_cnt_reg <= `BIT_CNT_RESET;
            during_reg  <= 1'b0;
            state_reg   <= ST_SHIFT;
          end
          else if (!busy_prev_reg && sync.busy)
          begin
            shift_reg   <= result_i;
            bit_cnt_reg <= `BIT_CNT_RESET;
            during_reg  <= 1'b1;
            state_reg   <= ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          // Rising edge latches cascade input, opposite to the shift edge
          if (enabled && sync.sclk_rise)
            casc_bit_reg <= (!during_reg) ? sync.casc_in : 1'b0;
          // Falling edge advances one bit; between pulses only a busy edge moves the word
          if (enabled && sync.sclk_fall)
          begin
            shift_reg   <= {shift_reg[RESULT_W-2:0], casc_bit_reg};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == 5'(RESULT_W - 1) && during_reg)
              state_reg <= ST_DONE;
          end
          // Conversion end always brings the fresh word, even after a cut read
          if (busy_prev_reg && !sync.busy)
          begin
            shift_reg   <= result_i;
            bit_cnt_reg <= `BIT_CNT_RESET;
            during_reg  <= 1'b0;
            state_reg   <= ST_SHIFT;
          end
          // Conversion start reloads unless our own word is part read, which carries on
          else if (!busy_prev_reg && sync.busy && !during_reg
                   && (bit_cnt_reg == `BIT_CNT_RESET || bit_cnt_reg[4]))
          begin
            shift_reg   <= result_i;
            bit_cnt_reg <= `BIT_CNT_RESET;
            during_reg  <= 1'b1;
          end
        end
        ST_DONE:
          state_reg <= ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Output pin: released whenever not selected
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      serial_result_out_o      <= 1'b0;
      serial_result_out_oe_n_o <= 1'b1;
      read_active_o            <= 1'b0;
    end
    else
    begin
      serial_result_out_o      <= shift_reg[RESULT_W-1];
      serial_result_out_oe_n_o <= ~enabled;
      read_active_o            <= (state_reg == ST_SHIFT);
    end
  end

  // Conversion ended during a read begun in that conversion, with bits still outstanding
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
      read_overrun_pulse_o <= 1'b0;
    else
      read_overrun_pulse_o <= port_on && state_reg == ST_SHIFT && during_reg
                              && busy_prev_reg && !sync.busy
                              && bit_cnt_reg != `BIT_CNT_RESET;
  end
endmodule

// file: serial_result_readout_props.sv
// Purpose: Port assertions for the serial readout
// Assumes: Pin sync plus register delay stays under six cycles
// Notes:   Bound to every instance of the readout
`timescale 1ns/1ps
module serial_result_readout_props
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic serial_parallel_select_i,
  input wire logic clock_source_select_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic busy_i,
  input wire logic serial_result_out_o,
  input wire logic serial_result_out_oe_n_o,
  input wire logic read_overrun_pulse_o,
  input wire logic read_active_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // Short names keep each check readable
  wire on = serial_parallel_select_i & clock_source_select_i;
  wire oe_n = serial_result_out_oe_n_o;
  wire dq = serial_result_out_o;
  wire ovr = read_overrun_pulse_o;
  wire [5:0] pins = {sclk_i, cs_n_i, rd_n_i, busy_i, on, 1'b0};
  // Windows allow for the two-stage pin synchronisers
  a_oe_desel: assert property ((cs_n_i | rd_n_i)[*6] |-> oe_n)
    else $error("driven unselected");
  a_oe_mode: assert property ((!on)[*6] |-> oe_n)
    else $error("driven in other mode");
  a_oe_drive: assert property ((!cs_n_i && !rd_n_i && on)[*8] |-> !oe_n)
    else $error("not driven");
  a_bit_hold: assert property ($stable(pins)[*8] |-> $stable(dq))
    else $error("bit moved while paused");
  a_gate_clk: assert property ((cs_n_i && $stable({busy_i, rd_n_i, on}))[*8] |-> $stable(dq))
    else $error("bit moved unselected");
  a_err_width: assert property (ovr |=> !ovr)
    else $error("error pulse too long");
  a_err_cause: assert property (ovr |-> !busy_i && $past(busy_i, 7))
    else $error("error pulse without conversion end");
  a_load_word: assert property ($fell(busy_i) && on |-> ##[3:6] read_active_o)
    else $error("word not loaded");
  // Main scenarios reached
  c_err: cover property (ovr);
  c_load: cover property ($rose(read_active_o));
  c_drive: cover property ($fell(oe_n));
endmodule

bind serial_result_readout serial_result_readout_props props_i (.core_clk_i, .nrst_i,
  .serial_parallel_select_i, .clock_source_select_i, .sclk_i, .cs_n_i, .rd_n_i, .busy_i,
  .serial_result_out_o, .serial_result_out_oe_n_o, .read_overrun_pulse_o, .read_active_o);

// file: host_spi_model.sv
// Purpose: Host master that clocks words out of the readout port
// Assumes: Polarity 0, phase 0, 80 ns link clock
// Notes:   Clock stands low between frames and during pauses
`timescale 1ns/1ps
module host_spi_model
(
  input  wire logic   sdo_i,
  output logic        sclk_o,
  output logic        cs_n_o,
  output logic        done_o,
  output logic [31:0] word_o
);
  initial {sclk_o, cs_n_o, done_o} = 3'b010;
  // Sample just before each rise; 12.5 MHz keeps well under 40
  task automatic frame(input int n, input int gap, input bit sel, input bit rep);
    word_o = 32'h0000_0000;
    cs_n_o = !sel;
    #60;
    for (int i = 0; i < n; i++)
    begin
      if (i == gap)
        #600;
      word_o = {word_o[30:0], sdo_i};
      sclk_o = 1'b1;
      #40;
      sclk_o = 1'b0;
      #40;
    end
    cs_n_o = 1'b1;
    done_o = rep;
    #5;
    done_o = 1'b0;
  endtask
endmodule

// file: serial_result_readout_tb_top.sv
// Purpose: Self-checking bench for the serial readout port
// Assumes: Expected words derive from the result fed in
// Notes:   Upstream converter is a shift register on the cascade input
`timescale 1ns/1ps
module serial_result_readout_tb_top
  import readout_pkg::*;
;
  logic         clk = 1'b0, nrst = 1'b0, ser = 1'b1, src = 1'b1, rd_n = 1'b0, busy = 1'b0;
  logic         sd_last = 1'b0;
  result_word_t res = 16'h0000;
  logic [15:0]  up = 16'h0000, s = 16'h0034;
  logic [31:0]  wq[$];
  logic         oq[$];
  int           err_count = 0, samples_checked = 0;
  wire          sclk, cs_n, dout, oe_n, ovr, done, sdw;
  wire [31:0]   word;
  // A released data line shows the inverse of its last level
  assign sdw = oe_n ? ~sd_last : dout;
  always @(posedge clk) sd_last <= sdw;
  // Upstream part shifts on the falling link edge
  always @(negedge sclk) up <= {up[14:0], 1'b0};
  initial forever #2.5 clk = ~clk;
  serial_result_readout serial_result_readout_i (.core_clk_i(clk), .nrst_i(nrst),
    .serial_parallel_select_i(ser), .clock_source_select_i(src),
    .cascade_in_read_mode_sel_i(up[15]), .sclk_i(sclk), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .busy_i(busy), .result_i(res), .serial_result_out_o(dout),
    .serial_result_out_oe_n_o(oe_n), .read_overrun_pulse_o(ovr), .read_active_o());
  host_spi_model host_spi_model_i (.sdo_i(sdw), .sclk_o(sclk), .cs_n_o(cs_n),
    .done_o(done), .word_o(word));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  // Oldest note taken as each result appears
  always @(posedge done) chk(word, wq.pop_front());
  always @(posedge clk) if (ovr === 1'b1) chkb(ovr, oq.pop_front());
  // One conversion; n bits of the previous result read while busy is high
  task automatic rdc(input int n);
    @(negedge clk) busy = 1'b1;
    repeat (10) @(negedge clk);
    if (n > 0)
    begin
      wq.push_back(32'(res >> (16 - n)));
      host_spi_model_i.frame(n, 99, 1'b1, 1'b1);
    end
    repeat (60) @(negedge clk);
    if (n % 16 != 0)
      oq.push_back(1'b1);
    s = lfsr(s);
    res = s;
    busy = 1'b0;
    repeat (20) @(negedge clk);
  endtask
  task automatic summarize();
    chk(32'(wq.size() + oq.size()), 32'h0000_0000);
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    rdc(0);
    // Chained read with a pause: own word, then the upstream word
    s = lfsr(s);
    up = s; // Upstream part converted on the same start as ours
    wq.push_back({res, up});
    host_spi_model_i.frame(32, 8, 1'b1, 1'b1);
    $display("chain read done");
    rdc(0);
    // Clocks while deselected or in another mode must leave the word alone
    for (int m = 0; m < 4; m++)
    begin
      @(negedge clk) {ser, src, rd_n} = 3'b110 ^ 3'(4'b1000 >> m);
      host_spi_model_i.frame(16, 99, m != 0, 1'b0);
    end
    @(negedge clk) {ser, src, rd_n} = 3'b110;
    wq.push_back({16'h0000, res});
    host_spi_model_i.frame(16, 99, 1'b1, 1'b1);
    $display("gated clock test done");
    rdc(16);
    rdc(8);
    $display("read during conversion done");
    // Read begun after conversion runs on into the next one
    wq.push_back({16'h0000, res});
    fork
      host_spi_model_i.frame(16, 99, 1'b1, 1'b1);
      begin
        #500;
        @(negedge clk) busy = 1'b1;
      end
    join
    repeat (40) @(negedge clk);
    busy = 1'b0;
    repeat (20) @(negedge clk);
    $display("read across conversion done");
    summarize();
  end
  // Hang guard
  initial
  begin
    repeat (60000) @(posedge clk);
    err_count++;
    summarize();
  end
endmodule
